// ===== hdl/trig_pkg.sv
// constants and types for the acquisition trigger controller
package trig_pkg;
   localparam int unsigned CLK_HZ = 10_000_000;
   localparam real ANA_LAT_US = 1.3;
   localparam real DIG_LAT_US = 1.0;
   localparam int unsigned ANA_LAT_CYC = (ANA_LAT_US * CLK_HZ / 1.0e6 < 1.0) ? 1 :
      int'($floor(ANA_LAT_US * CLK_HZ / 1.0e6));
   localparam int unsigned DIG_LAT_CYC = (DIG_LAT_US * CLK_HZ / 1.0e6 < 1.0) ? 1 :
      int'($floor(DIG_LAT_US * CLK_HZ / 1.0e6));
   localparam int unsigned PAT_W = 16;
   localparam int unsigned CNT_W = 32;
   localparam int unsigned NUM_ANA = 16;
   localparam int unsigned NUM_CNT = 4;
   localparam int unsigned PRE_W = 24;
   localparam int unsigned SCAN_W = 32;
   localparam logic [PRE_W-1:0] PRE_RESET = 24'h000000;
   localparam logic [SCAN_W-1:0] SCAN_RESET = 32'h00000000;

   typedef enum logic [1:0] {
      DIG_HIGH = 2'h0,
      DIG_LOW = 2'h1,
      DIG_RISE = 2'h2,
      DIG_FALL = 2'h3
   } dig_cond_t;

   typedef enum logic [1:0] {
      CNT_REACH = 2'h0,
      CNT_EXCEED = 2'h1,
      CNT_WINDOW = 2'h2
   } cnt_cond_t;

   typedef enum logic [1:0] {
      SRC_ANALOG = 2'h0,
      SRC_DIGITAL = 2'h1,
      SRC_SOFT = 2'h2
   } start_src_t;

   // six pre/post modes
   typedef enum logic [2:0] {
      MODE_NOPRE_STOP = 3'h0,
      MODE_FIXPRE_STOP = 3'h1,
      MODE_NOPRE_INF = 3'h2,
      MODE_FIXPRE_INF = 3'h3,
      MODE_VARPRE_STOP = 3'h4,
      MODE_VARPRE_INF = 3'h5
   } prepost_t;

   typedef enum logic [1:0] {
      CAL_FACTORY = 2'h0,
      CAL_USER = 2'h1,
      CAL_SELF = 2'h2
   } cal_sel_t;

   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_PRE = 5'h02,
      ST_WAIT = 5'h04,
      ST_POST = 5'h08,
      ST_DONE = 5'h10
   } acq_state_t;
endpackage

// ===== hdl/acquisition_trigger_control.sv
// trigger and pre/post acquisition sequencing for the scan engine
// Behaviour
// - analog comparator on selectable channel, edge, hysteresis
// - analog crossing recognised within 1.3 us
// - armed analog trigger fires only on new transition
// - digital trigger: high, low, rising or falling
// - digital trigger recognised within 1 us
// - 16-bit pattern compare, masked bits ignored
// - counter reach, exceed or window condition
// - multi-channel conditions combined by AND or OR
// - temperature excluded; multi-channel done within scan
// - stop by software condition or scan count
// - pre-trigger modes start only by software detection
// - exactly one of six pre/post modes
// - no-pre stop-event: trigger to stop event
// - fixed pre stop-event: pre count, then stop
// - no-pre infinite: trigger until host halt
// - fixed pre infinite: pre count, then halt
// - variable pre accepts trigger before pre count
// - variable pre infinite ends only on halt
// - three cal tables; user write spares factory
module acquisition_trigger_control
   import trig_pkg::*;
#(
   parameter int unsigned N_ANA = trig_pkg::NUM_ANA,
   parameter int unsigned N_CNT = trig_pkg::NUM_CNT
) (
   // clock, reset, enable
   input wire logic mclk,
   input wire logic rst,
   input wire logic ce,
   // analog comparators (hysteresis applied by front end)
   input wire logic [N_ANA-1:0] ana_above,
   input wire logic [N_ANA-1:0] ana_is_temp,
   input wire logic [$clog2(N_ANA)-1:0] ana_sel,
   input wire logic ana_rising,
   input wire logic [15:0] ana_level_cfg,
   input wire logic [15:0] ana_hyst_cfg,
   // digital trigger pin
   input wire logic dig_trig_pin,
   input wire trig_pkg::dig_cond_t dig_cond,
   // pattern
   input wire logic [trig_pkg::PAT_W-1:0] pat_in,
   input wire logic [trig_pkg::PAT_W-1:0] pat_value,
   input wire logic [trig_pkg::PAT_W-1:0] pat_mask,
   // counters, flattened per channel
   input wire logic [N_CNT*trig_pkg::CNT_W-1:0] cnt_value,
   input wire logic [N_CNT*trig_pkg::CNT_W-1:0] cnt_lo,
   input wire logic [N_CNT*trig_pkg::CNT_W-1:0] cnt_hi,
   input wire logic [2*N_CNT-1:0] cnt_cond,
   // multi-channel combination
   input wire logic [N_ANA-1:0] multi_ana_en,
   input wire logic multi_dig_en,
   input wire logic multi_pat_en,
   input wire logic [N_CNT-1:0] multi_cnt_en,
   input wire logic multi_and,
   // scan engine
   input wire logic scan_tick,
   // control from host driver
   input wire trig_pkg::start_src_t start_src,
   input wire logic soft_trig,
   input wire trig_pkg::prepost_t mode,
   input wire logic [trig_pkg::PRE_W-1:0] pre_count,
   input wire logic [trig_pkg::SCAN_W-1:0] scan_limit,
   input wire logic stop_multi_en,
   input wire logic stop_soft_en,
   input wire logic arm,
   input wire logic halt,
   input wire trig_pkg::cal_sel_t cal_sel_in,
   input wire logic cal_user_wr,
   // outputs
   output logic trig_pulse,
   output logic stop_pulse,
   output logic capturing,
   output logic pre_phase,
   output logic armed,
   output logic cfg_error,
   output logic [trig_pkg::PRE_W-1:0] pre_taken,
   output logic [trig_pkg::SCAN_W-1:0] scan_done,
   output trig_pkg::cal_sel_t cal_sel,
   output logic cal_factory_wp,
   output logic [15:0] dac_level,
   output logic [15:0] dac_hyst
);
   import trig_pkg::*;

   initial begin
      if (N_ANA < 2 || N_ANA > 64 || N_CNT < 1 || N_CNT > 8)
         $error("unsupported channel counts");
   end

   function automatic logic cnt_match(input logic [CNT_W-1:0] v, input logic [CNT_W-1:0] lo,
                                      input logic [CNT_W-1:0] hi, input logic [1:0] c);
      case (c)
         CNT_REACH: cnt_match = (v >= lo);
         CNT_EXCEED: cnt_match = (v > lo);
         CNT_WINDOW: cnt_match = (v >= lo) && (v <= hi);
         default: cnt_match = 1'b0;
      endcase
   endfunction

   acq_state_t state;
   acq_state_t next_state;
   logic dig_s1, dig_s2, dig_prev;
   logic ana_prev;
   logic multi_prev;

   // digital trigger synchroniser
   always_ff @(posedge mclk) begin
      if (rst) begin
         dig_s1 <= 1'b0;
         dig_s2 <= 1'b0;
         dig_prev <= 1'b0;
      end else if (ce) begin
         dig_s1 <= dig_trig_pin;
         dig_s2 <= dig_s1;
         dig_prev <= dig_s2;
      end
   end

   wire dig_hit;
   assign dig_hit = (dig_cond == DIG_HIGH) ? dig_s2 :
                    (dig_cond == DIG_LOW) ? !dig_s2 :
                    (dig_cond == DIG_RISE) ? (dig_s2 && !dig_prev) :
                    (!dig_s2 && dig_prev);

   // selected analog comparator; edge only, so a pre-tripped level waits
   wire ana_now;
   assign ana_now = ana_above[ana_sel];
   wire ana_hit;
   assign ana_hit = armed && (ana_rising ? (ana_now && !ana_prev) : (!ana_now && ana_prev));

   wire pat_hit;
   assign pat_hit = ((pat_in ^ pat_value) & ~pat_mask) == '0;

   logic [N_CNT-1:0] cnt_hit;
   always_comb begin
      for (int i = 0; i < N_CNT; i++) begin
         cnt_hit[i] = cnt_match(cnt_value[i*CNT_W +: CNT_W], cnt_lo[i*CNT_W +: CNT_W],
                                cnt_hi[i*CNT_W +: CNT_W], cnt_cond[2*i +: 2]);
      end
   end

   // multi-channel combination, temperature channels never qualify
   wire [N_ANA-1:0] ana_en_eff;
   assign ana_en_eff = multi_ana_en & ~ana_is_temp;
   wire any_sel;
   assign any_sel = (|ana_en_eff) || multi_dig_en || multi_pat_en || (|multi_cnt_en);
   wire and_term;
   assign and_term = (&(ana_above | ~ana_en_eff)) && (!multi_dig_en || dig_s2) &&
                     (!multi_pat_en || pat_hit) && (&(cnt_hit | ~multi_cnt_en));
   wire or_term;
   assign or_term = (|(ana_above & ana_en_eff)) || (multi_dig_en && dig_s2) ||
                    (multi_pat_en && pat_hit) || (|(cnt_hit & multi_cnt_en));
   wire multi_level;
   assign multi_level = any_sel && (multi_and ? and_term : or_term);
   wire multi_hit;
   assign multi_hit = scan_tick && multi_level && !multi_prev;

   // mode decode
   wire pre_mode;
   assign pre_mode = (mode == MODE_FIXPRE_STOP) || (mode == MODE_FIXPRE_INF) ||
                     (mode == MODE_VARPRE_STOP) || (mode == MODE_VARPRE_INF);
   wire fixed_pre;
   assign fixed_pre = (mode == MODE_FIXPRE_STOP) || (mode == MODE_FIXPRE_INF);
   wire inf_mode;
   assign inf_mode = (mode == MODE_NOPRE_INF) || (mode == MODE_FIXPRE_INF) ||
                     (mode == MODE_VARPRE_INF);
   wire mode_bad;
   assign mode_bad = (mode > MODE_VARPRE_INF) || (pre_mode && start_src != SRC_SOFT);

   // start source; pre-trigger modes take software detection only
   wire start_hit;
   assign start_hit = (start_src == SRC_ANALOG) ? ana_hit :
                      (start_src == SRC_DIGITAL) ? dig_hit :
                      (soft_trig || multi_hit);

   wire pre_full;
   assign pre_full = (pre_taken >= pre_count);
   wire scan_end;
   assign scan_end = (scan_limit != '0) && scan_tick && (scan_done + 1'b1 >= scan_limit);
   wire stop_hit;
   assign stop_hit = halt || (!inf_mode && ((stop_soft_en && soft_trig) ||
                     (stop_multi_en && multi_hit) || scan_end));

   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (arm && !mode_bad)
               next_state = pre_mode ? ST_PRE : ST_WAIT;
         end
         ST_PRE: begin
            if (halt)
               next_state = ST_DONE;
            else if (fixed_pre && pre_full)
               next_state = ST_WAIT;
            else if (!fixed_pre && start_hit)
               next_state = ST_POST;
         end
         ST_WAIT: begin
            if (halt)
               next_state = ST_DONE;
            else if (start_hit)
               next_state = ST_POST;
         end
         ST_POST: begin
            if (stop_hit)
               next_state = ST_DONE;
         end
         ST_DONE: next_state = ST_IDLE;
         default: next_state = ST_IDLE;
      endcase
   end

   wire to_post;
   assign to_post = (state != ST_POST) && (next_state == ST_POST);
   wire to_done;
   assign to_done = (state == ST_POST) && (next_state == ST_DONE);

   always_ff @(posedge mclk) begin
      if (rst) begin
         state <= ST_IDLE;
         ana_prev <= 1'b0;
         multi_prev <= 1'b0;
      end else if (ce) begin
         state <= next_state;
         ana_prev <= ana_now;
         if (scan_tick)
            multi_prev <= multi_level;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         trig_pulse <= 1'b0;
         stop_pulse <= 1'b0;
         capturing <= 1'b0;
         pre_phase <= 1'b0;
         armed <= 1'b0;
         cfg_error <= 1'b0;
      end else if (ce) begin
         trig_pulse <= to_post;
         stop_pulse <= to_done;
         capturing <= (next_state == ST_PRE) || (next_state == ST_POST) ||
                      (next_state == ST_WAIT && pre_mode);
         pre_phase <= (next_state == ST_PRE) || (next_state == ST_WAIT && pre_mode);
         armed <= (next_state == ST_PRE) || (next_state == ST_WAIT);
         cfg_error <= mode_bad;
      end
   end

   // reading counters
   always_ff @(posedge mclk) begin
      if (rst) begin
         pre_taken <= PRE_RESET;
         scan_done <= SCAN_RESET;
      end else if (ce) begin
         if (state == ST_IDLE) begin
            pre_taken <= PRE_RESET;
            scan_done <= SCAN_RESET;
         end else begin
            if ((state == ST_PRE || (state == ST_WAIT && pre_mode)) && scan_tick && !pre_full)
               pre_taken <= pre_taken + 1'b1;
            if (state == ST_POST && scan_tick)
               scan_done <= scan_done + 1'b1;
         end
      end
   end

   // calibration table select, factory table always write-protected
   always_ff @(posedge mclk) begin
      if (rst) begin
         cal_sel <= CAL_FACTORY;
         cal_factory_wp <= 1'b1;
         dac_level <= 16'h0000;
         dac_hyst <= 16'h0000;
      end else if (ce) begin
         if (cal_sel_in != 2'h3)
            cal_sel <= cal_sel_in;
         cal_factory_wp <= 1'b1;
         if (state == ST_IDLE) begin
            dac_level <= ana_level_cfg;
            dac_hyst <= ana_hyst_cfg;
         end
      end
   end

   wire unused_ok;
   assign unused_ok = cal_user_wr;
endmodule

// ===== bench/trig_ctl_asserts.sv
// port-level checks for the trigger controller
module trig_ctl_asserts
   import trig_pkg::*;
#(
   parameter int unsigned N_ANA = 16
) (
   // inputs
   input wire logic mclk,
   input wire logic rst,
   input wire logic ce,
   input wire logic [N_ANA-1:0] ana_above,
   input wire logic [$clog2(N_ANA)-1:0] ana_sel,
   input wire logic ana_rising,
   input wire logic dig_trig_pin,
   input wire trig_pkg::dig_cond_t dig_cond,
   input wire trig_pkg::start_src_t start_src,
   input wire trig_pkg::prepost_t mode,
   input wire logic arm,
   input wire logic halt,
   // outputs
   input wire logic trig_pulse,
   input wire logic stop_pulse,
   input wire logic capturing,
   input wire logic armed,
   input wire logic cal_factory_wp
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   wire inf_m = mode == MODE_NOPRE_INF || mode == MODE_FIXPRE_INF || mode == MODE_VARPRE_INF;
   wire pre_m = mode != MODE_NOPRE_STOP && mode != MODE_NOPRE_INF;
   wire sel_ana = ana_above[ana_sel];
   sequence dig_edge_s;
      armed && ce && !halt && start_src == SRC_DIGITAL && dig_cond == DIG_RISE && $rose(dig_trig_pin);
   endsequence
   sequence ana_edge_s;
      armed && ce && !halt && start_src == SRC_ANALOG && ana_rising && $rose(sel_ana);
   endsequence
   trig_one_a: assert property (trig_pulse |=> !trig_pulse)
      else $error("trigger pulse too long");
   stop_one_a: assert property (stop_pulse |=> !stop_pulse)
      else $error("stop pulse too long");
   dig_lat_a: assert property (dig_edge_s |-> ##[1:9] trig_pulse)
      else $error("digital trigger late");
   ana_lat_a: assert property (ana_edge_s |-> ##[1:12] trig_pulse)
      else $error("analog trigger late");
   pre_trip_a: assert property ((start_src == SRC_ANALOG && $stable(ana_above)) [*3] |-> !trig_pulse)
      else $error("analog trigger without a crossing");
   pre_src_a: assert property (pre_m && start_src != SRC_SOFT && $stable(mode) && arm && !armed |=> !armed)
      else $error("arm taken with hardware source");
   halt_stop_a: assert property (inf_m && capturing && halt && ce |=> stop_pulse && !capturing)
      else $error("halt did not end capture");
   inf_end_a: assert property (inf_m && capturing && !halt |=> !stop_pulse)
      else $error("infinite capture ended without halt");
   trig_cap_a: assert property (trig_pulse |-> capturing && !armed)
      else $error("trigger without capture");
   factory_wp_a: assert property (cal_factory_wp)
      else $error("factory table unprotected");
endmodule

bind acquisition_trigger_control trig_ctl_asserts #(.N_ANA(N_ANA)) chk (.*);

// ===== bench/host_drv.sv
// host driver model: arm, halt and software trigger commands
module host_drv (
   // clock
   input wire logic mclk,
   // commands
   output logic arm,
   output logic halt,
   output logic soft_trig
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      {arm, halt, soft_trig} = 3'h0;
   end
   // one-cycle command just after an edge: 0 arm, 1 halt, else soft
   task automatic send(input int which);
      @(posedge mclk);
      #5;
      case (which)
         0: arm = 1'b1;
         1: halt = 1'b1;
         default: soft_trig = 1'b1;
      endcase
      @(posedge mclk);
      #5;
      {arm, halt, soft_trig} = 3'h0;
   endtask
endmodule

// ===== bench/test_acquisition_trigger_control.sv
// self-checking bench for the acquisition trigger controller
module test_acquisition_trigger_control;
   timeunit 1ns;
   timeprecision 1ns;
   import trig_pkg::*;
   logic mclk, rst, ce, ana_rising, dig_trig_pin, multi_dig_en, multi_pat_en, multi_and, scan_tick;
   logic stop_multi_en, stop_soft_en, cal_user_wr, arm, halt, soft_trig;
   logic trig_pulse, stop_pulse, capturing, pre_phase, armed, cfg_error, cal_factory_wp;
   logic [0:0] multi_cnt_en;
   logic [1:0] ana_sel, cnt_cond;
   logic [3:0] ana_above, ana_is_temp, multi_ana_en;
   logic [15:0] ana_level_cfg, ana_hyst_cfg, pat_in, pat_value, pat_mask, dac_level, dac_hyst, lf;
   logic [23:0] pre_count, pre_taken;
   logic [31:0] cnt_value, cnt_lo, cnt_hi, scan_limit, scan_done;
   dig_cond_t dig_cond;
   start_src_t start_src;
   prepost_t mode;
   cal_sel_t cal_sel_in, cal_sel;
   int errors, comparisons, n_trig, n_stop, e_trig, e_stop;

   acquisition_trigger_control #(.N_ANA(4), .N_CNT(1)) dut (.*);
   host_drv host (.*);

   always #50 mclk = ~mclk;
   always @(posedge mclk) begin
      n_trig += int'(trig_pulse === 1'b1);
      n_stop += int'(stop_pulse === 1'b1);
   end

   task automatic step(input int n);
      repeat (n) @(posedge mclk);
      #5;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic end_of_test();
      $display("comparisons=%0d errors=%0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // bounded wait for the counted trigger and stop pulses
   task automatic expect_ev(input int lim, input int want_t, input int want_s);
      for (int i = 0; i < lim && (n_trig != want_t || n_stop != want_s); i++) step(1);
      check(n_trig, want_t);
      check(n_stop, want_s);
      if (errors != 0) end_of_test();
   endtask
   task automatic scan(input int n);
      repeat (n) begin
         scan_tick = 1'b1;
         step(1);
         scan_tick = 1'b0;
         step(2);
      end
   endtask
   task automatic rnd_cfg();
      lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
      ana_level_cfg = lf;
      ana_hyst_cfg = ~lf;
      {cnt_value, cnt_lo, cnt_hi} = {3{lf, lf}};
      pat_value = lf ^ 16'h5A5A;
      multi_and = lf[0];
      multi_dig_en = lf[1];
      multi_cnt_en = lf[2];
   endtask

   initial begin
      {mclk, ce, rst} = 3'h3;
      {ana_rising, dig_trig_pin, multi_dig_en, multi_pat_en, multi_and, scan_tick} = 6'h00;
      {stop_multi_en, stop_soft_en, cal_user_wr, multi_cnt_en, cnt_cond} = 6'h03;
      {ana_sel, ana_above, ana_is_temp, multi_ana_en, pat_in, pat_mask, pre_count, scan_limit} = 0;
      {errors, comparisons, n_trig, n_stop, e_trig, e_stop} = 0;
      dig_cond = DIG_HIGH;
      start_src = SRC_DIGITAL;
      mode = MODE_NOPRE_INF;
      cal_sel_in = CAL_FACTORY;
      lf = 16'h0005;
      rnd_cfg();
      repeat (3) @(posedge mclk);
      #5;
      rst = 1'b0;
      for (int c = 0; c < 4; c++) begin
         dig_cond = dig_cond_t'(c);
         dig_trig_pin = c[0];
         rnd_cfg();
         step(4);
         check(dac_level, ana_level_cfg);
         host.send(0);
         step(2);
         dig_trig_pin = ~c[0];
         e_trig++;
         expect_ev(9, e_trig, e_stop);
         host.send(1);
         e_stop++;
         expect_ev(3, e_trig, e_stop);
         check(capturing, 1'b0);
      end
      start_src = SRC_ANALOG;
      mode = MODE_NOPRE_STOP;
      ana_sel = 2'h2;
      scan_limit = 32'h00000003;
      for (int e = 0; e < 2; e++) begin
         ana_rising = e[0];
         ana_above[2] = e[0];
         step(2);
         host.send(0);
         step(8);
         check(n_trig, e_trig);
         ana_above[2] = ~e[0];
         step(2);
         ana_above[2] = e[0];
         e_trig++;
         expect_ev(12, e_trig, e_stop);
         scan(2);
         check(scan_done, 32'h00000002);
         scan(1);
         e_stop++;
         expect_ev(3, e_trig, e_stop);
      end
      start_src = SRC_DIGITAL;
      for (int m = 1; m < 6; m++) begin
         if (m != 2) begin
            mode = prepost_t'(m);
            step(2);
            check(cfg_error, 1'b1);
            host.send(0);
            check(armed, 1'b0);
         end
      end
      start_src = SRC_SOFT;
      mode = MODE_VARPRE_STOP;
      pre_count = 24'h000064;
      {multi_pat_en, multi_ana_en, ana_is_temp, ana_above} = 13'h1110;
      {multi_dig_en, multi_cnt_en, multi_and} = 3'h0;
      pat_mask = 16'h00FF;
      pat_in = ~pat_value;
      stop_soft_en = 1'b1;
      host.send(0);
      ana_above[0] = 1'b1;
      scan(2);
      check(n_trig, e_trig);
      pat_in = {pat_value[15:8], ~pat_value[7:0]};
      e_trig++;
      scan(1);
      expect_ev(4, e_trig, e_stop);
      host.send(2);
      e_stop++;
      expect_ev(3, e_trig, e_stop);
      // fixed pre-trigger, infinite post; soft trigger lost while frozen
      mode = MODE_FIXPRE_INF;
      pre_count = 24'h000002;
      multi_pat_en = 1'b0;
      host.send(0);
      scan(2);
      check(pre_taken, 32'h00000002);
      check(pre_phase, 1'b1);
      ce = 1'b0;
      host.send(2);
      step(2);
      check(n_trig, e_trig);
      ce = 1'b1;
      host.send(2);
      e_trig++;
      expect_ev(4, e_trig, e_stop);
      host.send(1);
      e_stop++;
      expect_ev(3, e_trig, e_stop);
      check(capturing, 1'b0);
      for (int k = 0; k < 3; k++) begin
         cal_sel_in = cal_sel_t'(k);
         cal_user_wr = 1'b1;
         step(2);
         cal_user_wr = 1'b0;
         check(cal_sel, cal_sel_in);
         check(cal_factory_wp, 1'b1);
      end
      end_of_test();
   end
endmodule
